// ==== logic/sleep_ctrl_pkg.sv ====
// Package: register map, field positions, mode codes and timing for the sleep controller
package sleep_ctrl_pkg;
    // ------------------------------------------------------------------
    // Register map (3-bit word index, 8-bit data)
    // ------------------------------------------------------------------
    localparam int ADDR_W = 3;
    localparam int DATA_W = 8;
    localparam logic [2:0] A_SLEEP_CTRL = 3'h0;
    localparam logic [2:0] A_CORE_CTRL = 3'h1;
    localparam logic [2:0] A_CMP_CTRL = 3'h2;
    localparam logic [2:0] A_WAKE_CFG = 3'h3;
    localparam logic [2:0] A_STATUS = 3'h4;

    // ------------------------------------------------------------------
    // Field positions and reset values
    // ------------------------------------------------------------------
    localparam int SE_BIT = 0;
    localparam int SM_LSB = 1;
    localparam int BROWNOUT_SLEEP_OFF_BIT = 6;
    localparam int BROWNOUT_SLEEP_OFF_EN_BIT = 5;
    localparam int CPD_BIT = 7;
    localparam int CFG_T2_ASYNC = 0;
    localparam int CFG_XTAL = 1;
    localparam int CFG_LVL_A = 2;
    localparam int CFG_LVL_B = 3;
    localparam int CFG_ADC_EN = 4;
    localparam int CFG_W = 5;
    localparam logic [2:0] SM_RESET = 3'h0;
    localparam logic [4:0] CFG_RESET = 5'h00;

    // ------------------------------------------------------------------
    // Sleep mode codes
    // ------------------------------------------------------------------
    localparam logic [2:0] M_IDLE = 3'h0;
    localparam logic [2:0] M_ADCNR = 3'h1;
    localparam logic [2:0] M_PDOWN = 3'h2;
    localparam logic [2:0] M_PSAVE = 3'h3;
    localparam logic [2:0] M_STBY = 3'h6;
    localparam logic [2:0] M_XSTBY = 3'h7;

    typedef enum logic [3:0] {
        ST_RUN = 4'h1,
        ST_SLEEP = 4'h2,
        ST_START = 4'h4,
        ST_HALT = 4'h8
    } state_t;

    // ------------------------------------------------------------------
    // Timing
    // ------------------------------------------------------------------
    localparam int CNT_W = 10;
    localparam int CLK_PERIOD_NS = 100;
    localparam int BOD_WAKE_NS = 60000;
    localparam logic [9:0] BOD_WAKE_CYC = 10'((BOD_WAKE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
    localparam logic [9:0] STBY_WAKE_CYC = 10'h006;
    localparam logic [9:0] FAST_WAKE_CYC = 10'h001;
    localparam logic [9:0] HALT_CYC = 10'h004;
    localparam logic [2:0] UNLOCK_CYC = 3'h4;
endpackage

// ==== logic/timed_unlock.sv ====
// Timed two-write unlock guarding the brownout sleep-off bit
module timed_unlock #(
    parameter logic [2:0] WIN_CYC = sleep_ctrl_pkg::UNLOCK_CYC
) (
    input wire logic i_clk,   // System clock
    input wire logic i_srst,  // Synchronous reset
    input wire logic i_wr,    // Write to the control register
    input wire logic i_value, // Written value of the guarded bit
    input wire logic i_arm,   // Written value of the enable bit
    output logic o_value,     // Guarded bit
    output logic o_open       // Unlock window open
);
    logic [2:0] win_q;
    logic value_q;
    wire arm_wr = i_wr && i_arm && i_value;
    wire commit_wr = i_wr && !i_arm && (win_q != 3'h0);
    wire clear_wr = i_wr && !i_arm && !i_value;

    // Rearming inside the window neither extends nor closes it
    always_ff @(posedge i_clk) begin
        if (i_srst) begin
            win_q <= 3'h0;
        end else if (commit_wr) begin
            win_q <= 3'h0;
        end else if (arm_wr && win_q == 3'h0) begin
            win_q <= WIN_CYC;
        end else if (win_q != 3'h0) begin
            win_q <= win_q - 3'h1;
        end
    end

    // Setting needs the sequence; clearing back to safe is always allowed
    always_ff @(posedge i_clk) begin
        if (i_srst) begin
            value_q <= 1'b0; // R13
        end else if (commit_wr) begin
            value_q <= i_value; // R17
        end else if (clear_wr) begin
            value_q <= 1'b0;
        end
    end

    assign o_value = value_q;
    assign o_open = win_q != 3'h0;

    set_needs_seq_a: assert property (@(posedge i_clk) disable iff (i_srst) // R17
        i_wr && !i_arm && i_value && win_q == 3'h0 && !value_q |=> !value_q)
        else $error("guarded bit set without unlock");
endmodule // timed_unlock

// ==== logic/sleep_mode_controller.sv ====
// Sleep-mode controller: clock domain gating, wake selection and wake sequencing
// What this block does
// R1: Sleep starts only on sleep instruction with sleep_enable set; mode field picks mode.
// R2: Mode 000 Idle stops only CPU and flash clocks.
// R3: Idle wakes on external and all internal interrupts.
// R4: comparator_power_down removes the comparator as a wake source and powers it off.
// R5: Mode 001 stops I/O, CPU and flash clocks; converter and asynchronous parts run.
// R6: Entering converter noise mode with converter enabled starts a conversion.
// R7: Converter noise mode wakes only on its listed sources.
// R8: Outside Idle, the two external pins wake only when level-triggered.
// R9: Timer 2 wake outside Idle, and asynchronous clock, stay only in asynchronous timer mode.
// R10: Interrupt wake holds CPU four cycles past start-up, then services interrupt.
// R11: Register file and static RAM keep their contents across sleep.
// R12: A reset during sleep wakes and restarts from the reset vector.
// R13: brownout_sleep_off 1 disables detector in allowed modes; resets to 0.
// R14: Detector disable only in Power-down, Power-save, Standby, Extended Standby.
// R15: Detector goes off right after entry and returns on wake.
// R16: After a sleep with detector off, resume waits about 60 us.
// R17: brownout_sleep_off is set only through a timed enable sequence; clearing it to 0 needs no sequence.
// R18: Software should use Standby only with a crystal clock source.
// R19: Mode 010 Power-down stops oscillator and all generated clocks.
// R20: Mode 011 Power-save is Power-down plus a running timer 2 wake.
// R21: Modes 110/111 with crystal keep oscillator and wake in six cycles.
// R22: Sleep instruction with sleep_enable clear is a no-operation.
// R23: Wake logic runs on the ungated clock so works while I/O clock stops.
//
// The placing of the registers and the plain strobed port were decided locally.
module sleep_mode_controller #(
    parameter logic [9:0] STARTUP_CYC = 10'h010
) (
    input wire logic i_clk,            // Ungated system clock
    input wire logic i_srst,           // Synchronous reset, active high
    input wire logic [2:0] i_addr,     // Register index
    input wire logic [7:0] i_wdata,    // Write data
    input wire logic i_wr,             // Write strobe
    input wire logic i_rd,             // Read strobe
    output logic [7:0] o_rdata,        // Read data, cycle after strobe
    input wire logic i_sleep_instr,    // CPU executes sleep, one pulse
    input wire logic i_reset_wake,     // Reset request during sleep
    input wire logic i_ext_irq_a,      // External pin a interrupt
    input wire logic i_ext_irq_b,      // External pin b interrupt
    input wire logic i_pin_change_irq, // Pin change interrupt
    input wire logic i_twi_match,      // Two-wire address match
    input wire logic i_timer2_irq,     // Timer 2 interrupt
    input wire logic i_self_prog_irq,  // Self-program / EEPROM ready
    input wire logic i_adc_done_irq,   // Conversion complete
    input wire logic i_watchdog_irq,   // Watchdog interrupt
    input wire logic i_cmp_irq,        // Analog comparator interrupt
    input wire logic i_other_irq,      // Other I/O interrupts
    output logic o_cpu_clk_en,         // cpu_clock enable
    output logic o_flash_clk_en,       // flash_clock enable
    output logic o_io_clk_en,          // io_clock enable
    output logic o_adc_clk_en,         // converter_clock enable
    output logic o_asy_clk_en,         // Timer 2 asynchronous clock enable
    output logic o_main_osc_en,        // Main oscillator enable
    output logic o_bod_en,             // brownout_detector enable
    output logic o_cmp_power_off,      // Comparator powered down
    output logic o_adc_start,          // Start conversion, one pulse
    output logic o_irq_service,        // Resume into interrupt, one pulse
    output logic o_reset_vector,       // Resume at reset vector, one pulse
    output logic o_sleeping            // Block is asleep or waking
);
    // ------------------------------------------------------------------
    // Register bus
    // ------------------------------------------------------------------
    logic se_q;
    logic [2:0] sm_q;
    logic cpd_q;
    logic [4:0] cfg_q;
    logic brownout_sleep_off;
    logic unlock_open;
    wire wr_sleep = i_wr && i_addr == sleep_ctrl_pkg::A_SLEEP_CTRL;
    wire wr_core = i_wr && i_addr == sleep_ctrl_pkg::A_CORE_CTRL;
    wire wr_cmp = i_wr && i_addr == sleep_ctrl_pkg::A_CMP_CTRL;
    wire wr_cfg = i_wr && i_addr == sleep_ctrl_pkg::A_WAKE_CFG;
    wire t2_async = cfg_q[sleep_ctrl_pkg::CFG_T2_ASYNC];
    wire xtal = cfg_q[sleep_ctrl_pkg::CFG_XTAL];

    always_ff @(posedge i_clk) begin
        if (i_srst) begin
            se_q <= 1'b0;
            sm_q <= sleep_ctrl_pkg::SM_RESET;
        end else if (wr_sleep) begin
            se_q <= i_wdata[sleep_ctrl_pkg::SE_BIT];
            sm_q <= i_wdata[sleep_ctrl_pkg::SM_LSB +: 3];
        end
    end

    always_ff @(posedge i_clk) begin
        if (i_srst) begin
            cpd_q <= 1'b0;
            cfg_q <= sleep_ctrl_pkg::CFG_RESET;
        end else begin
            if (wr_cmp) cpd_q <= i_wdata[sleep_ctrl_pkg::CPD_BIT];
            if (wr_cfg) cfg_q <= i_wdata[4:0];
        end
    end

    timed_unlock u_brownout_sleep_off_unlock (
        .i_clk(i_clk),
        .i_srst(i_srst),
        .i_wr(wr_core),
        .i_value(i_wdata[sleep_ctrl_pkg::BROWNOUT_SLEEP_OFF_BIT]),
        .i_arm(i_wdata[sleep_ctrl_pkg::BROWNOUT_SLEEP_OFF_EN_BIT]),
        .o_value(brownout_sleep_off),
        .o_open(unlock_open)
    );

    // ------------------------------------------------------------------
    // Mode decode
    // ------------------------------------------------------------------
    // Without a crystal, standby codes fall back to Power-down / Power-save
    function automatic logic [2:0] eff_mode(input logic [2:0] sm, input logic xt);
        eff_mode = (sm[2:1] == 2'b11 && !xt) ? {2'b01, sm[0]} : sm;
    endfunction

    function automatic logic is_deep(input logic [2:0] m);
        is_deep = m[1];
    endfunction

    sleep_ctrl_pkg::state_t state_q, state_d;
    logic [2:0] mode_q;
    logic bod_off_q;
    logic cause_reset_q;
    logic [9:0] cnt_q;
    wire [2:0] mode_now = eff_mode(sm_q, xtal);
    wire mode_legal = sm_q[2:1] != 2'b10;
    wire is_run = state_q == sleep_ctrl_pkg::ST_RUN;
    wire is_sleep = state_q == sleep_ctrl_pkg::ST_SLEEP;
    wire is_start = state_q == sleep_ctrl_pkg::ST_START;
    wire is_halt = state_q == sleep_ctrl_pkg::ST_HALT;
    // Disabled sleep_enable leaves the CPU running
    wire go_sleep = is_run && i_sleep_instr && se_q && mode_legal; // R1 R22
    wire bod_may_off = brownout_sleep_off && is_deep(mode_now); // R13 R14

    // ------------------------------------------------------------------
    // Wake sources, evaluated on the ungated clock
    // ------------------------------------------------------------------
    wire m_idle = mode_q == sleep_ctrl_pkg::M_IDLE;
    wire m_adcnr = mode_q == sleep_ctrl_pkg::M_ADCNR;
    wire m_t2 = mode_q[0] || !mode_q[1];
    wire ext_ok = (i_ext_irq_a && (m_idle || cfg_q[sleep_ctrl_pkg::CFG_LVL_A]))
        || (i_ext_irq_b && (m_idle || cfg_q[sleep_ctrl_pkg::CFG_LVL_B])); // R8
    wire t2_ok = i_timer2_irq && (m_idle || (t2_async && m_t2)); // R9 R20
    wire common_ok = ext_ok || i_pin_change_irq || i_twi_match || i_watchdog_irq; // R19 R23
    wire idle_ok = m_idle && (i_other_irq || (i_cmp_irq && !cpd_q)); // R3 R4
    wire adc_ok = (m_idle || m_adcnr) && (i_adc_done_irq || i_self_prog_irq); // R7
    wire irq_wake = is_sleep && (common_ok || t2_ok || idle_ok || adc_ok);
    wire rst_wake = is_sleep && i_reset_wake; // R12
    wire wake = irq_wake || rst_wake;

    // ------------------------------------------------------------------
    // Wake timing
    // ------------------------------------------------------------------
    wire [9:0] base_cyc = is_deep(mode_q)
        ? (mode_q[2] ? sleep_ctrl_pkg::STBY_WAKE_CYC : STARTUP_CYC) // R21
        : sleep_ctrl_pkg::FAST_WAKE_CYC;
    wire [9:0] wake_cyc = (bod_off_q && base_cyc < sleep_ctrl_pkg::BOD_WAKE_CYC)
        ? sleep_ctrl_pkg::BOD_WAKE_CYC : base_cyc; // R16
    wire cnt_last = cnt_q == 10'h001;

    // ------------------------------------------------------------------
    // Sequencer
    // ------------------------------------------------------------------
    always_comb begin
        state_d = state_q;
        unique case (state_q)
            sleep_ctrl_pkg::ST_RUN: begin
                if (go_sleep) state_d = sleep_ctrl_pkg::ST_SLEEP;
            end
            sleep_ctrl_pkg::ST_SLEEP: begin
                if (wake) state_d = sleep_ctrl_pkg::ST_START;
            end
            sleep_ctrl_pkg::ST_START: begin
                if (cnt_last) state_d = sleep_ctrl_pkg::ST_HALT;
            end
            sleep_ctrl_pkg::ST_HALT: begin
                if (cnt_last) state_d = sleep_ctrl_pkg::ST_RUN;
            end
        endcase
    end

    always_ff @(posedge i_clk) begin
        if (i_srst) begin
            state_q <= sleep_ctrl_pkg::ST_RUN;
        end else begin
            state_q <= state_d;
        end
    end

    always_ff @(posedge i_clk) begin
        if (i_srst) begin
            cnt_q <= 10'h000;
        end else if (wake) begin
            cnt_q <= wake_cyc;
        end else if (is_start && cnt_last) begin
            cnt_q <= sleep_ctrl_pkg::HALT_CYC; // R10
        end else if (cnt_q != 10'h000) begin
            cnt_q <= cnt_q - 10'h001;
        end
    end

    always_ff @(posedge i_clk) begin
        if (i_srst) begin
            mode_q <= sleep_ctrl_pkg::M_IDLE;
            bod_off_q <= 1'b0;
        end else if (go_sleep) begin
            mode_q <= mode_now;
            bod_off_q <= bod_may_off;
        end else if (is_run) begin
            bod_off_q <= 1'b0;
        end
    end

    // A reset arriving during the wake count still wins over the interrupt
    always_ff @(posedge i_clk) begin
        if (i_srst) begin
            cause_reset_q <= 1'b0;
        end else if (go_sleep) begin
            cause_reset_q <= 1'b0;
        end else if (rst_wake || ((is_start || is_halt) && i_reset_wake)) begin
            cause_reset_q <= 1'b1; // R12
        end
    end

    // ------------------------------------------------------------------
    // Clock enables, all registered from the next state
    // ------------------------------------------------------------------
    // Gating only stops clocks; storage is never reset here, so contents stay
    wire asleep_d = state_d == sleep_ctrl_pkg::ST_SLEEP; // R11
    wire [2:0] mode_d = go_sleep ? mode_now : mode_q;
    wire idle_d = mode_d == sleep_ctrl_pkg::M_IDLE;
    wire adcnr_d = mode_d == sleep_ctrl_pkg::M_ADCNR;
    wire run_d = state_d == sleep_ctrl_pkg::ST_RUN;
    wire io_d = !asleep_d || idle_d; // R2 R5
    wire adc_d = !asleep_d || idle_d || adcnr_d; // R5
    wire asy_d = t2_async && (!asleep_d || idle_d || mode_d[0]); // R9 R20
    wire osc_d = !asleep_d || !is_deep(mode_d) || mode_d[2]; // R19 R21
    wire bod_d = !(asleep_d && (go_sleep ? bod_may_off : bod_off_q)); // R15
    wire resume = is_halt && cnt_last;

    always_ff @(posedge i_clk) begin
        if (i_srst) begin
            o_cpu_clk_en <= 1'b1;
            o_flash_clk_en <= 1'b1;
            o_io_clk_en <= 1'b1;
            o_adc_clk_en <= 1'b1;
            o_asy_clk_en <= 1'b0;
            o_main_osc_en <= 1'b1;
            o_bod_en <= 1'b1;
            o_sleeping <= 1'b0;
        end else begin
            o_cpu_clk_en <= run_d; // R2 R10
            o_flash_clk_en <= run_d;
            o_io_clk_en <= io_d;
            o_adc_clk_en <= adc_d;
            o_asy_clk_en <= asy_d;
            o_main_osc_en <= osc_d;
            o_bod_en <= bod_d;
            o_sleeping <= !run_d;
        end
    end

    always_ff @(posedge i_clk) begin
        if (i_srst) begin
            o_adc_start <= 1'b0;
            o_irq_service <= 1'b0;
            o_reset_vector <= 1'b0;
            o_cmp_power_off <= 1'b0;
        end else begin
            o_adc_start <= go_sleep && mode_now == sleep_ctrl_pkg::M_ADCNR
                && cfg_q[sleep_ctrl_pkg::CFG_ADC_EN]; // R6
            o_irq_service <= resume && !cause_reset_q && !i_reset_wake; // R10
            o_reset_vector <= resume && (cause_reset_q || i_reset_wake); // R12
            o_cmp_power_off <= cpd_q; // R4
        end
    end

    // ------------------------------------------------------------------
    // Read-back
    // ------------------------------------------------------------------
    wire [7:0] status_word = {1'b0, cause_reset_q, unlock_open, bod_off_q, state_q};
    wire [7:0] rd_mux =
        (i_addr == sleep_ctrl_pkg::A_SLEEP_CTRL) ? {4'h0, sm_q, se_q} :
        (i_addr == sleep_ctrl_pkg::A_CORE_CTRL) ? {1'b0, brownout_sleep_off, 6'h00} :
        (i_addr == sleep_ctrl_pkg::A_CMP_CTRL) ? {cpd_q, 7'h00} :
        (i_addr == sleep_ctrl_pkg::A_WAKE_CFG) ? {3'h0, cfg_q} :
        (i_addr == sleep_ctrl_pkg::A_STATUS) ? status_word : 8'h00;

    always_ff @(posedge i_clk) begin
        if (i_srst) begin
            o_rdata <= 8'h00;
        end else begin
            o_rdata <= i_rd ? rd_mux : 8'h00;
        end
    end

    // ------------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------------
    default clocking cb @(posedge i_clk); endclocking
    default disable iff (i_srst);

    sleep_nop_a: assert property ( // R22
        is_run && i_sleep_instr && !se_q |=> is_run && o_cpu_clk_en)
        else $error("sleep with enable clear left run state");
    sleep_entry_a: assert property ( // R1
        go_sleep |=> is_sleep && !o_cpu_clk_en && !o_flash_clk_en)
        else $error("sleep entry did not gate cpu clock");
    idle_clocks_a: assert property ( // R2
        go_sleep && mode_now == sleep_ctrl_pkg::M_IDLE |=> o_io_clk_en && o_adc_clk_en)
        else $error("idle stopped a peripheral clock");
    noise_clocks_a: assert property ( // R5
        go_sleep && mode_now == sleep_ctrl_pkg::M_ADCNR |=> !o_io_clk_en && o_adc_clk_en)
        else $error("noise mode clock gating wrong");
    adc_start_a: assert property ( // R6
        go_sleep && mode_now == sleep_ctrl_pkg::M_ADCNR && cfg_q[sleep_ctrl_pkg::CFG_ADC_EN]
        |=> o_adc_start)
        else $error("no conversion start on noise mode entry");
    halt_four_a: assert property ( // R10
        is_start && cnt_last |=> is_halt [*4] ##1 is_run)
        else $error("halt did not last four cycles");
    bod_kept_a: assert property ( // R14
        go_sleep && !is_deep(mode_now) |=> o_bod_en)
        else $error("detector disabled in shallow mode");
    bod_back_a: assert property ( // R15
        wake |=> o_bod_en && is_start)
        else $error("detector not re-enabled on wake");
    bod_delay_a: assert property ( // R16
        wake && bod_off_q |=> is_start [*8])
        else $error("wake after detector off too short");
    edge_pin_a: assert property ( // R8
        is_sleep && !m_idle && !cfg_q[sleep_ctrl_pkg::CFG_LVL_A] && !cfg_q[sleep_ctrl_pkg::CFG_LVL_B]
        && !i_pin_change_irq && !i_twi_match && !i_watchdog_irq && !t2_ok && !adc_ok
        && !i_reset_wake |=> is_sleep)
        else $error("edge pin woke from deep sleep");

    cover_idle_c: cover property (go_sleep && mode_now == sleep_ctrl_pkg::M_IDLE ##[1:50] resume);
    cover_bod_c: cover property (wake && bod_off_q);
    cover_reset_c: cover property (o_reset_vector);
endmodule // sleep_mode_controller

// ==== test/cpu_core_model.sv ====
// CPU core model that issues the sleep instruction
module cpu_core_model (
    input wire logic i_clk,        // System clock
    input wire logic i_go,         // Bench asks for one sleep
    input wire logic i_cpu_clk_en, // Core clock running
    output logic o_sleep_instr     // Sleep instruction pulse
);
    timeunit 1ns;
    timeprecision 1ns;
    // A core with its clock stopped executes nothing
    always_ff @(posedge i_clk) begin
        o_sleep_instr <= i_go & i_cpu_clk_en;
    end
endmodule // cpu_core_model

// ==== test/sleep_mode_controller_tb.sv ====
// Bench for the sleep-mode controller: registers, sleep entry and wake timing
module sleep_mode_controller_tb;
    timeunit 1ns;
    timeprecision 1ns;
    localparam int SC = 4;
    localparam logic [2:0] MODES [6] = '{3'h0, 3'h1, 3'h2, 3'h3, 3'h6, 3'h7};
    localparam logic [5:0] ENS [6] = '{6'h0f, 6'h07, 6'h00, 6'h02, 6'h01, 6'h03};
    localparam int STS [6] = '{1, 1, SC, SC, 6, 6};
    logic clk = 1'b0;
    logic srst = 1'b1;
    logic [2:0] addr = 3'h0;
    logic [7:0] wdata = 8'h00;
    logic wr = 1'b0;
    logic rd = 1'b0;
    logic go = 1'b0;
    logic [10:0] src = 11'h000;
    logic sleep_instr;
    logic [7:0] rdata;
    logic [5:0] en;
    logic bod_en, cmp_off, adc_start, irq_srv, rst_vec, sleeping;
    int n_mismatch = 0;
    int checks = 0;

    always #50 clk = ~clk;

    cpu_core_model cpu_u (.i_clk(clk), .i_go(go), .i_cpu_clk_en(en[5]),
        .o_sleep_instr(sleep_instr));

    sleep_mode_controller #(.STARTUP_CYC(10'(SC))) dut_u (
        .i_clk(clk), .i_srst(srst), .i_addr(addr), .i_wdata(wdata), .i_wr(wr),
        .i_rd(rd), .o_rdata(rdata), .i_sleep_instr(sleep_instr),
        .i_reset_wake(src[10]), .i_ext_irq_a(src[0]), .i_ext_irq_b(src[1]),
        .i_pin_change_irq(src[2]), .i_twi_match(src[3]), .i_timer2_irq(src[4]),
        .i_self_prog_irq(src[5]), .i_adc_done_irq(src[6]), .i_watchdog_irq(src[7]),
        .i_cmp_irq(src[8]), .i_other_irq(src[9]), .o_cpu_clk_en(en[5]),
        .o_flash_clk_en(en[4]), .o_io_clk_en(en[3]), .o_adc_clk_en(en[2]),
        .o_asy_clk_en(en[1]), .o_main_osc_en(en[0]), .o_bod_en(bod_en),
        .o_cmp_power_off(cmp_off), .o_adc_start(adc_start), .o_irq_service(irq_srv),
        .o_reset_vector(rst_vec), .o_sleeping(sleeping));

    // --------
    // Tasks
    // --------
    task automatic check(input string what, input logic [15:0] seen, exp);
        checks++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("unexpected %s: expected %h seen %h", what, exp, seen);
        end
    endtask

    task automatic conclude();
        if (n_mismatch == 0 && checks > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask

    // Gap cycle after each strobe keeps one assignment per time step
    task automatic wreg(input logic [2:0] a, input logic [7:0] d);
        addr <= a;
        wdata <= d;
        wr <= 1'b1;
        @(posedge clk);
        wr <= 1'b0;
        @(posedge clk);
    endtask

    task automatic rreg(input logic [2:0] a, input logic [7:0] exp);
        addr <= a;
        rd <= 1'b1;
        @(posedge clk);
        rd <= 1'b0;
        #1;
        check("rdata", rdata, exp);
        @(posedge clk);
    endtask

    task automatic enter(input logic [2:0] m, input logic [7:0] cfg, input logic se = 1'b1);
        wreg(3'h3, cfg);
        wreg(3'h0, {4'h0, m, se});
        go <= 1'b1;
        @(posedge clk);
        go <= 1'b0;
        @(posedge clk);
        #1;
    endtask

    // Source index 10 is the reset request
    task automatic wake(input int b, input int n);
        int k;
        k = 0;
        @(posedge clk);
        src[b] <= 1'b1;
        while (irq_srv !== 1'b1 && rst_vec !== 1'b1 && k < 2000) begin
            @(posedge clk);
            #1;
            k++;
        end
        check("wake_cycles", 16'(k), 16'(n));
        check("resume", {irq_srv, rst_vec, en[5], sleeping}, {b != 10, b == 10, 2'b10});
        @(posedge clk);
        src[b] <= 1'b0;
        @(posedge clk);
    endtask

    task automatic no_wake(input int b);
        @(posedge clk);
        src[b] <= 1'b1;
        repeat (20) @(posedge clk);
        #1;
        check("asleep", sleeping, 1'b1);
        @(posedge clk);
        src[b] <= 1'b0;
    endtask

    // --------
    // Tests
    // --------
    initial begin
        #1000000;
        n_mismatch++;
        conclude();
    end

    initial begin
        repeat (4) @(posedge clk);
        srst <= 1'b0;
        @(posedge clk);
        #1;
        check("reset_out", {en, bod_en, sleeping}, 8'hf6);
        @(posedge clk);
        rreg(3'h1, 8'h00);
        rreg(3'h5, 8'h00);
        for (int i = 0; i < 6; i++) begin
            enter(MODES[i], 8'h1f);
            check("clk_en", {en, adc_start}, {ENS[i], MODES[i] == 3'h1});
            wake(0, STS[i] + 5);
        end
        enter(3'h2, 8'h03);
        no_wake(0);
        wake(7, SC + 5);
        enter(3'h1, 8'h1f);
        no_wake(9);
        wake(6, 6);
        wreg(3'h2, 8'h80);
        enter(3'h0, 8'h1f);
        check("cmp_off", cmp_off, 1'b1);
        no_wake(8);
        wake(9, 6);
        wreg(3'h2, 8'h00);
        enter(3'h3, 8'h02);
        check("asy_clk", en[1], 1'b0);
        no_wake(4);
        wake(3, SC + 5);
        enter(3'h2, 8'h1f, 1'b0);
        check("nop", {en[5], sleeping}, 2'b10);
        @(posedge clk);
        enter(3'h4, 8'h1f);
        check("nop_code", {en[5], sleeping}, 2'b10);
        @(posedge clk);
        // Standby code without crystal falls back to Power-down
        enter(3'h6, 8'h1d);
        check("clk_en_noxtal", en, 6'h00);
        wake(0, SC + 5);
        wreg(3'h1, 8'h40);
        rreg(3'h1, 8'h00);
        wreg(3'h1, 8'h60);
        wreg(3'h1, 8'h40);
        rreg(3'h1, 8'h40);
        enter(3'h0, 8'h1f);
        check("bod_idle", bod_en, 1'b1);
        wake(0, 6);
        enter(3'h2, 8'h1f);
        check("bod_off", bod_en, 1'b0);
        wake(0, 605);
        check("bod_on", bod_en, 1'b1);
        wreg(3'h1, 8'h00);
        enter(3'h2, 8'h1f);
        wake(10, SC + 5);
        conclude();
    end
endmodule // sleep_mode_controller_tb
